/* File: verilog/status_flags_pkg.sv */
package status_flags_pkg;

  localparam int STATUS_WIDTH = 16;

  // field positions in the status word
  localparam int MASK_BIT = 0;
  localparam int OVERFLOW_BIT = 1;
  localparam int RESUME_BIT = 2;
  localparam int BREAKPOINT_OP_INT_BIT = 3;
  localparam int FP_PEND_BIT = 4;
  localparam int IMPL_BITS = 5;

  localparam logic [15:0] STATUS_RESET = 16'h0000;
  localparam logic [15:0] IMPL_MASK = 16'h001f;

  // fp unit wait and service entry/return take whole cycles
  localparam int FP_WAIT_LIMIT = 1;

  // operations presented by the instruction sequencer
  typedef enum logic [4:0] {
    OP_NONE,
    OP_BREAKPOINT,
    OP_POP_BLOCK_EXECUTE,
    OP_FIXED_TRAP_DISABLE,
    OP_FIXED_TRAP_ENABLE,
    OP_CALL_LONG,
    OP_CALL_SHORT,
    OP_STATUS_LOAD,
    OP_STATUS_STORE,
    OP_CONTEXT_POP,
    OP_WIDE_BLOCK_POP,
    OP_WIDE_RESTORE,
    OP_WIDE_RETURN,
    OP_SAVE_MASK_CLEAR,
    OP_SAVE_MASK_SET,
    OP_SPECIAL_SAVE_MASK_CLEAR,
    OP_SPECIAL_SAVE_MASK_SET,
    OP_VECTORED_INTERRUPT,
    OP_RESUMABLE_START
  } op_type;

  typedef enum logic [1:0] {
    SVC_IDLE,
    SVC_WAIT_FP,
    SVC_ACTIVE
  } svc_type;

endpackage

/* File: verilog/fp_service_guard.sv */
`timescale 1ns/1ps
module fp_service_guard (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic clkEn,
  // service sequencing
  input wire logic serviceReq,
  input wire logic serviceReturn,
  input wire logic fpBusy,
  input wire logic fpTrapEnableIn,
  input wire logic fpErrorSummary,
  input wire logic pendingBitIn,
  // results
  output logic serviceGrant,
  output logic enterStrobe,
  output logic returnStrobe,
  output logic nextPending,
  output logic nextTrapEnable
);

  status_flags_pkg::svc_type state_ff;
  status_flags_pkg::svc_type nxt_state;

  wire logic enterNow = (state_ff == status_flags_pkg::SVC_WAIT_FP) && !fpBusy;
  wire logic leaveNow = (state_ff == status_flags_pkg::SVC_ACTIVE) && serviceReturn;

  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      status_flags_pkg::SVC_IDLE: begin
        if (serviceReq) begin
          nxt_state = status_flags_pkg::SVC_WAIT_FP;
        end
      end
      status_flags_pkg::SVC_WAIT_FP: begin
        if (!fpBusy) begin
          nxt_state = status_flags_pkg::SVC_ACTIVE;
        end
      end
      status_flags_pkg::SVC_ACTIVE: begin
        if (serviceReturn) begin
          nxt_state = status_flags_pkg::SVC_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      state_ff <= status_flags_pkg::SVC_IDLE;
    end else if (clkEn) begin
      state_ff <= nxt_state;
    end
  end

  assign serviceGrant = enterNow;
  assign enterStrobe = enterNow;
  assign returnStrobe = leaveNow;
  assign nextPending = enterNow ? (fpTrapEnableIn && fpErrorSummary) : (leaveNow ? 1'b0 : pendingBitIn);
  assign nextTrapEnable = enterNow ? (fpTrapEnableIn && !(fpTrapEnableIn && fpErrorSummary)) :
                          (leaveNow ? pendingBitIn : fpTrapEnableIn);

  no_entry_busy_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (clkEn && fpBusy) |-> !serviceGrant) else $error("service entered while fp unit busy");

endmodule

/* File: verilog/processor_status_flags.sv */
// Overview of operation
// - sixteen-bit status word, instruction access only
// - breakpoint clears whole word
// - trap disable clears mask, enable sets
// - both calls clear overflow flag
// - save variants write mask zero or one
// - pops, restore, return reload word
// - vectored interrupt loads table word
// - mask must precede flag for fault
// - mask saved and restored across calls
// - narrow or wide overflow sets flag
// - transient overflow ignored before completion
// - flag sticky until listed clearing events
// - interrupted resumable instruction sets resume flag
// - resumable start tests and clears resume
// - interrupt during breakpoint op sets flag
// - breakpoint tests, clears, replays saved opcode
// - pop block execute runs saved op
// - fault-pending mirrors trap enable on error
// - wait for fp unit before service
// - entry copies enable, suppresses fp traps on error
// - return loads enable from the pending bit, clears pending
// - reserved bits store zero, load ignored
`timescale 1ns/1ps
module processor_status_flags (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic clkEn,
  // instruction sequencer
  input wire logic opValid,
  input wire status_flags_pkg::op_type opCode,
  input wire logic [15:0] accumulatorZero,
  input wire logic [15:0] stackWord,
  input wire logic [15:0] contextWord,
  input wire logic [15:0] tableWord,
  // arithmetic events
  input wire logic narrowOverflow,
  input wire logic wideOverflow,
  input wire logic instrComplete,
  // interrupt and fault events
  input wire logic ioInterruptAck,
  input wire logic faultServiced,
  input wire logic resumableInterrupted,
  input wire logic breakpointOpInterrupted,
  input wire logic serviceReq,
  input wire logic serviceReturn,
  // floating-point unit
  input wire logic fpBusy,
  input wire logic fpTrapEnableIn,
  input wire logic fpErrorSummary,
  // status and results
  output logic [15:0] statusStore,
  output logic overflowFault,
  output logic resumeRestore,
  output logic replaySaved,
  output logic pushSavedOpcode,
  output logic serviceGrant,
  output logic fpTrapEnable
);

  logic maskFf;
  logic overflowFf;
  logic resumeFf;
  logic bkptIntFf;
  logic fpPendFf;
  logic [15:0] store_ff;
  logic fault_ff;
  logic resume_ff;
  logic replay_ff;
  logic push_ff;
  logic grant_ff;
  logic trapEn_ff;

  logic nxt_mask;
  logic nxt_overflow;
  logic nxt_resume;
  logic nxt_bkptInt;
  logic nxt_fpPend;

  wire logic guardGrant;
  wire logic enterStrobe;
  wire logic returnStrobe;
  wire logic guardPending;
  wire logic guardTrapEn;

  fp_service_guard guard (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .clkEn(clkEn),
    .serviceReq(serviceReq),
    .serviceReturn(serviceReturn),
    .fpBusy(fpBusy),
    .fpTrapEnableIn(trapEn_ff),
    .fpErrorSummary(fpErrorSummary),
    .pendingBitIn(fpPendFf),
    .serviceGrant(guardGrant),
    .enterStrobe(enterStrobe),
    .returnStrobe(returnStrobe),
    .nextPending(guardPending),
    .nextTrapEnable(guardTrapEn)
  );

  // operation decode
  wire logic isOp = opValid;
  wire logic opBkpt = isOp && (opCode == status_flags_pkg::OP_BREAKPOINT);
  wire logic opPbx = isOp && (opCode == status_flags_pkg::OP_POP_BLOCK_EXECUTE);
  wire logic opTrapDis = isOp && (opCode == status_flags_pkg::OP_FIXED_TRAP_DISABLE);
  wire logic opTrapEn = isOp && (opCode == status_flags_pkg::OP_FIXED_TRAP_ENABLE);
  wire logic opCall = isOp && ((opCode == status_flags_pkg::OP_CALL_LONG) ||
                               (opCode == status_flags_pkg::OP_CALL_SHORT));
  wire logic opStore = isOp && (opCode == status_flags_pkg::OP_STATUS_STORE);
  wire logic opCtxPop = isOp && (opCode == status_flags_pkg::OP_CONTEXT_POP);
  wire logic opStackLoad = isOp && ((opCode == status_flags_pkg::OP_WIDE_BLOCK_POP) ||
                                    (opCode == status_flags_pkg::OP_WIDE_RESTORE) ||
                                    (opCode == status_flags_pkg::OP_WIDE_RETURN));
  wire logic opSaveClr = isOp && ((opCode == status_flags_pkg::OP_SAVE_MASK_CLEAR) ||
                                  (opCode == status_flags_pkg::OP_SPECIAL_SAVE_MASK_CLEAR));
  wire logic opSaveSet = isOp && ((opCode == status_flags_pkg::OP_SAVE_MASK_SET) ||
                                  (opCode == status_flags_pkg::OP_SPECIAL_SAVE_MASK_SET));
  wire logic opVector = isOp && (opCode == status_flags_pkg::OP_VECTORED_INTERRUPT);
  wire logic opResStart = isOp && (opCode == status_flags_pkg::OP_RESUMABLE_START);

  wire logic wordLoad = opCtxPop || opStackLoad || opVector;
  wire logic [15:0] loadWord = opCtxPop ? contextWord : (opVector ? tableWord : stackWord);
  wire logic [15:0] loadMasked = loadWord & status_flags_pkg::IMPL_MASK;
  wire logic [15:0] storeMasked = accumulatorZero & status_flags_pkg::IMPL_MASK;

  wire logic overflowNow = (narrowOverflow || wideOverflow) && instrComplete;
  wire logic faultNow = overflowNow && !overflowFf && maskFf;
  wire logic clearOverflow = ioInterruptAck || faultServiced;

  wire logic [15:0] statusWord = {11'h000, fpPendFf, bkptIntFf, resumeFf, overflowFf, maskFf};

  always_comb begin
    nxt_mask = maskFf;
    nxt_overflow = overflowFf;
    nxt_resume = resumeFf;
    nxt_bkptInt = bkptIntFf;
    nxt_fpPend = guardPending;
    if (clearOverflow) begin
      nxt_overflow = 1'b0;
    end
    if (opBkpt) begin
      nxt_mask = 1'b0;
      nxt_overflow = 1'b0;
      nxt_resume = 1'b0;
      nxt_bkptInt = 1'b0;
      nxt_fpPend = 1'b0;
    end
    if (opTrapDis) begin
      nxt_mask = 1'b0;
    end
    if (opTrapEn) begin
      nxt_mask = 1'b1;
    end
    if (opCall) begin
      nxt_overflow = 1'b0;
    end
    if (opSaveClr) begin
      nxt_mask = 1'b0;
    end
    if (opSaveSet) begin
      nxt_mask = 1'b1;
    end
    if (wordLoad || opStore) begin
      nxt_mask = wordLoad ? loadMasked[status_flags_pkg::MASK_BIT] : storeMasked[status_flags_pkg::MASK_BIT];
      nxt_overflow = wordLoad ? loadMasked[status_flags_pkg::OVERFLOW_BIT] :
                     storeMasked[status_flags_pkg::OVERFLOW_BIT];
      nxt_resume = wordLoad ? loadMasked[status_flags_pkg::RESUME_BIT] : storeMasked[status_flags_pkg::RESUME_BIT];
      nxt_bkptInt = wordLoad ? loadMasked[status_flags_pkg::BREAKPOINT_OP_INT_BIT] :
                    storeMasked[status_flags_pkg::BREAKPOINT_OP_INT_BIT];
      nxt_fpPend = wordLoad ? loadMasked[status_flags_pkg::FP_PEND_BIT] : storeMasked[status_flags_pkg::FP_PEND_BIT];
    end
    if (opResStart) begin
      nxt_resume = 1'b0;
    end
    if (resumableInterrupted) begin
      nxt_resume = 1'b1;
    end
    if (breakpointOpInterrupted) begin
      nxt_bkptInt = 1'b1;
    end
    if (overflowNow) begin
      nxt_overflow = 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      maskFf <= 1'b0;
      overflowFf <= 1'b0;
      resumeFf <= 1'b0;
      bkptIntFf <= 1'b0;
      fpPendFf <= 1'b0;
    end else if (clkEn) begin
      maskFf <= nxt_mask;
      overflowFf <= nxt_overflow;
      resumeFf <= nxt_resume;
      bkptIntFf <= nxt_bkptInt;
      fpPendFf <= nxt_fpPend;
    end
  end

  // registered outputs; store path is what the load-status instruction returns
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      store_ff <= status_flags_pkg::STATUS_RESET;
      fault_ff <= 1'b0;
      resume_ff <= 1'b0;
      replay_ff <= 1'b0;
      push_ff <= 1'b0;
      grant_ff <= 1'b0;
      trapEn_ff <= 1'b0;
    end else if (clkEn) begin
      store_ff <= statusWord & status_flags_pkg::IMPL_MASK;
      fault_ff <= faultNow;
      resume_ff <= opResStart && resumeFf;
      replay_ff <= (opBkpt && bkptIntFf) || opPbx;
      push_ff <= breakpointOpInterrupted;
      grant_ff <= guardGrant;
      // restore on return
      // traps stay off for the whole service while a capture is parked, not just the entry cycle
      trapEn_ff <= (enterStrobe || returnStrobe) ? guardTrapEn : (fpPendFf ? 1'b0 : fpTrapEnableIn);
    end
  end

  assign statusStore = store_ff;
  assign overflowFault = fault_ff;
  assign resumeRestore = resume_ff;
  assign replaySaved = replay_ff;
  assign pushSavedOpcode = push_ff;
  assign serviceGrant = grant_ff;
  assign fpTrapEnable = trapEn_ff;

  breakpoint_clears_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (clkEn && opBkpt && !resumableInterrupted && !breakpointOpInterrupted && !overflowNow) |=>
    (statusWord == 16'h0000)) else $error("breakpoint left status nonzero");

  trap_enable_mask_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (clkEn && opTrapEn && opValid) |=> maskFf) else $error("trap enable did not set mask");

  call_clears_ovf_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (clkEn && opCall && !overflowNow) |=> !overflowFf) else $error("call left overflow set");

  save_set_mask_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (clkEn && opSaveSet) |=> maskFf) else $error("save variant did not set mask");

  context_reload_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (clkEn && opCtxPop && !overflowNow && !resumableInterrupted && !breakpointOpInterrupted) |=>
    (statusWord == ($past(contextWord) & 16'h001f))) else $error("context pop reload wrong");

  fault_needs_mask_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    overflowFault |-> ($past(maskFf) && !$past(overflowFf))) else $error("fault raised without prior mask");

  overflow_sticky_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (clkEn && overflowNow) |=> overflowFf) else $error("overflow not captured");

  overflow_holds_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (clkEn && overflowFf && !clearOverflow && !isOp) |=> overflowFf) else $error("overflow flag dropped");

  resume_set_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (clkEn && resumableInterrupted) |=> resumeFf) else $error("resume flag not set");

  store_reserved_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    statusStore[15:5] == 11'h000) else $error("reserved bits stored nonzero");

  mask_gates_fault_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (clkEn && overflowNow && !overflowFf && maskFf) |=> overflowFault) else $error("masked-in overflow gave no fault");

  resume_restore_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (clkEn && opResStart && resumeFf) |=> resumeRestore) else $error("resume restore not requested");

  breakpoint_op_int_set_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (clkEn && breakpointOpInterrupted) |=> (bkptIntFf && pushSavedOpcode)) else $error("breakpoint interrupt not recorded");

  replay_request_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (clkEn && (opPbx || (opBkpt && bkptIntFf))) |=> replaySaved) else $error("saved opcode replay not requested");

  trap_suppressed_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (clkEn && fpPendFf && !enterStrobe && !returnStrobe) |=> !fpTrapEnable) else $error("fp trap enabled during service");

endmodule

/* File: test/fp_unit_model.sv */
`timescale 1ns/1ps
module fp_unit_model (
  // clock
  input wire logic ref_clk,
  // bench control
  input wire logic startFp,
  input wire logic [3:0] busyLen,
  input wire logic trapEnable,
  input wire logic errorSeen,
  // toward the status block
  output logic fpBusy,
  output logic fpTrapEnableIn,
  output logic fpErrorSummary
);
  logic [3:0] countFf;
  initial countFf = 4'h0;
  // busy for a set number of cycles after each start, so the service wait shows
  always @(posedge ref_clk) begin
    if (startFp) begin
      countFf <= busyLen;
    end else if (countFf != 4'h0) begin
      countFf <= countFf - 4'h1;
    end
  end
  assign fpBusy = (countFf != 4'h0);
  assign fpTrapEnableIn = trapEnable;
  assign fpErrorSummary = errorSeen;
endmodule

/* File: test/processor_status_flags_tb.sv */
`timescale 1ns/1ps
module processor_status_flags_tb;
  typedef status_flags_pkg::op_type op_type;
  localparam logic [8:0] NOV = 9'h001, WOV = 9'h002, DONE = 9'h004, IOACK = 9'h008;
  localparam logic [8:0] FSVC = 9'h010, RINT = 9'h020, BINT = 9'h040, SREQ = 9'h080, SRET = 9'h100;
  logic ref_clk, rst_n, clkEn, opValid, startFp, fpTe, fpErr, fpBusy, fpTeIn, fpErrSum;
  op_type opCode;
  logic [15:0] accWord, stackWord, contextWord, tableWord, statusStore;
  logic [8:0] ev;
  logic [3:0] busyLen;
  logic overflowFault, resumeRestore, replaySaved, pushSavedOpcode, serviceGrant, fpTrapEnable;
  int errCount, cmpCount, cycles;

  processor_status_flags DUT (.ref_clk(ref_clk), .rst_n(rst_n), .clkEn(clkEn), .opValid(opValid),
    .opCode(opCode), .accumulatorZero(accWord), .stackWord(stackWord), .contextWord(contextWord),
    .tableWord(tableWord), .narrowOverflow(ev[0]), .wideOverflow(ev[1]), .instrComplete(ev[2]),
    .ioInterruptAck(ev[3]), .faultServiced(ev[4]), .resumableInterrupted(ev[5]),
    .breakpointOpInterrupted(ev[6]), .serviceReq(ev[7]), .serviceReturn(ev[8]), .fpBusy(fpBusy),
    .fpTrapEnableIn(fpTeIn), .fpErrorSummary(fpErrSum), .statusStore(statusStore),
    .overflowFault(overflowFault), .resumeRestore(resumeRestore), .replaySaved(replaySaved),
    .pushSavedOpcode(pushSavedOpcode), .serviceGrant(serviceGrant), .fpTrapEnable(fpTrapEnable));

  fp_unit_model fpUnit (.ref_clk(ref_clk), .startFp(startFp), .busyLen(busyLen), .trapEnable(fpTe),
    .errorSeen(fpErr), .fpBusy(fpBusy), .fpTrapEnableIn(fpTeIn), .fpErrorSummary(fpErrSum));

  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end

  task automatic completeRun();
    $display("comparisons %0d mismatches %0d", cmpCount, errCount);
    if (errCount == 0 && cmpCount > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 3000) begin
      errCount++;
      $display("CHECK FAILED %0t run timed out", $time);
      completeRun();
    end
  end

  task automatic chkW(input string m, input logic [15:0] got, input logic [15:0] exp);
    cmpCount++;
    if (got !== exp) begin
      errCount++;
      $display("CHECK FAILED %0t %s got %h expected %h", $time, m, got, exp);
    end
  endtask

  task automatic chkB(input string m, input logic got, input logic exp);
    chkW(m, {15'h0000, got}, {15'h0000, exp});
  endtask

  // called at a falling edge; holds the request for exactly one rising edge
  task automatic step(input op_type op, input logic [8:0] e);
    opValid = (op != status_flags_pkg::OP_NONE);
    opCode = op;
    ev = e;
    @(negedge ref_clk);
    opValid = 1'b0;
    opCode = status_flags_pkg::OP_NONE;
    ev = 9'h000;
  endtask

  // pulses stand for the cycle right after the taking edge; the stored word follows one edge later
  task automatic look(input string m, input logic [15:0] w, input logic [3:0] p);
    chkW(m, {12'h000, overflowFault, resumeRestore, replaySaved, pushSavedOpcode}, {12'h000, p});
    @(negedge ref_clk);
    chkW(m, statusStore, w);
  endtask

  task automatic testMask();
    op_type saveOps[4];
    saveOps = '{status_flags_pkg::OP_SAVE_MASK_CLEAR, status_flags_pkg::OP_SAVE_MASK_SET,
      status_flags_pkg::OP_SPECIAL_SAVE_MASK_CLEAR, status_flags_pkg::OP_SPECIAL_SAVE_MASK_SET};
    chkW("after reset", statusStore, 16'h0000);
    step(status_flags_pkg::OP_FIXED_TRAP_ENABLE, 9'h000);
    look("trap on", 16'h0001, 4'h0);
    step(status_flags_pkg::OP_FIXED_TRAP_DISABLE, 9'h000);
    look("trap off", 16'h0000, 4'h0);
    for (int i = 0; i < 4; i++) begin
      step(saveOps[i], 9'h000);
      look("save", {15'h0000, i[0]}, 4'h0);
    end
    $display("test mask done");
  endtask

  task automatic testLoads();
    // hardware-owned bits 2-4 left clear in the stored word
    accWord = 16'hffe1;
    step(status_flags_pkg::OP_STATUS_STORE, 9'h000);
    look("store", 16'h0001, 4'h0);
    contextWord = 16'hff02;
    step(status_flags_pkg::OP_CONTEXT_POP, 9'h000);
    look("context", 16'h0002, 4'h0);
    for (int i = 0; i < 3; i++) begin
      stackWord = 16'hffe0 | 16'(i + 1);
      step(op_type'(int'(status_flags_pkg::OP_WIDE_BLOCK_POP) + i), 9'h000);
      look("stack", 16'(i + 1), 4'h0);
    end
    tableWord = 16'h8001;
    step(status_flags_pkg::OP_VECTORED_INTERRUPT, 9'h000);
    look("vector", 16'h0001, 4'h0);
    $display("test loads done");
  endtask

  task automatic testOverflow();
    step(status_flags_pkg::OP_NONE, NOV);
    look("no complete", 16'h0001, 4'h0);
    step(status_flags_pkg::OP_NONE, NOV | DONE);
    look("narrow", 16'h0003, 4'h8);
    step(status_flags_pkg::OP_NONE, WOV | DONE);
    look("sticky", 16'h0003, 4'h0);
    step(status_flags_pkg::OP_CALL_LONG, 9'h000);
    look("call long", 16'h0001, 4'h0);
    step(status_flags_pkg::OP_FIXED_TRAP_DISABLE, 9'h000);
    look("mask off", 16'h0000, 4'h0);
    step(status_flags_pkg::OP_NONE, WOV | DONE);
    look("masked", 16'h0002, 4'h0);
    step(status_flags_pkg::OP_CALL_SHORT, 9'h000);
    look("call short", 16'h0000, 4'h0);
    step(status_flags_pkg::OP_NONE, WOV | DONE);
    look("wide", 16'h0002, 4'h0);
    step(status_flags_pkg::OP_NONE, IOACK);
    look("io ack", 16'h0000, 4'h0);
    step(status_flags_pkg::OP_NONE, NOV | DONE);
    look("narrow again", 16'h0002, 4'h0);
    step(status_flags_pkg::OP_NONE, FSVC);
    look("fault done", 16'h0000, 4'h0);
    $display("test overflow done");
  endtask

  task automatic testResumeBreak();
    step(status_flags_pkg::OP_NONE, RINT);
    look("resume set", 16'h0004, 4'h0);
    step(status_flags_pkg::OP_RESUMABLE_START, 9'h000);
    look("resume", 16'h0000, 4'h4);
    step(status_flags_pkg::OP_RESUMABLE_START, 9'h000);
    look("fresh", 16'h0000, 4'h0);
    step(status_flags_pkg::OP_FIXED_TRAP_ENABLE, 9'h000);
    look("mask on", 16'h0001, 4'h0);
    step(status_flags_pkg::OP_NONE, BINT);
    look("breakpoint_op set", 16'h0009, 4'h1);
    step(status_flags_pkg::OP_BREAKPOINT, 9'h000);
    look("breakpoint_op replay", 16'h0000, 4'h2);
    step(status_flags_pkg::OP_BREAKPOINT, 9'h000);
    look("breakpoint_op plain", 16'h0000, 4'h0);
    step(status_flags_pkg::OP_POP_BLOCK_EXECUTE, 9'h000);
    look("pop execute", 16'h0000, 4'h2);
    $display("test resume and breakpoint done");
  endtask

  task automatic testFp(input logic err);
    int n;
    fpTe = 1'b1;
    fpErr = err;
    startFp = 1'b1;
    @(negedge ref_clk);
    startFp = 1'b0;
    step(status_flags_pkg::OP_NONE, SREQ);
    n = 0;
    while (serviceGrant !== 1'b1 && n < 20) begin
      @(negedge ref_clk);
      n++;
    end
    chkB("grant", serviceGrant, 1'b1);
    chkB("fp wait", n >= 3, 1'b1);
    chkB("trap held", fpTrapEnable, !err);
    @(negedge ref_clk);
    chkB("grant ends", serviceGrant, 1'b0);
    chkW("pending", statusStore, {11'h000, err, 4'h0});
    chkB("trap still held", fpTrapEnable, !err);
    step(status_flags_pkg::OP_NONE, SRET);
    look("fp return", 16'h0000, 4'h0);
    if (err) chkB("trap back", fpTrapEnable, 1'b1);
    $display("test fp service done");
  endtask

  task automatic testFreeze();
    clkEn = 1'b0;
    step(status_flags_pkg::OP_FIXED_TRAP_ENABLE, 9'h000);
    look("frozen", 16'h0000, 4'h0);
    clkEn = 1'b1;
    $display("test freeze done");
  endtask

  initial begin
    {rst_n, opValid, startFp, fpTe, fpErr} = 5'h00;
    clkEn = 1'b1;
    opCode = status_flags_pkg::OP_NONE;
    {accWord, stackWord, contextWord, tableWord} = 64'h0;
    ev = 9'h000;
    busyLen = 4'h4;
    errCount = 0;
    cmpCount = 0;
    cycles = 0;
    repeat (8) @(negedge ref_clk);
    rst_n = 1'b1;
    @(negedge ref_clk);
    testMask();
    testLoads();
    testOverflow();
    testResumeBreak();
    testFp(1'b1);
    testFp(1'b0);
    testFreeze();
    completeRun();
  end
endmodule
